// file: tse_pkg.sv
// Constants, field layouts and state type of the ternary search engine front end.
package tse_pkg;

  // ---------------------------------------------------------------------------
  // Bus widths and field positions.
  // ---------------------------------------------------------------------------
  localparam int DQ_W       = 68;
  localparam int OP_W       = 9;
  localparam int CMD_LSB    = 0;
  localparam int CMD_W      = 2;
  localparam int TGT_LSB    = 2;
  localparam int TGT_W      = 2;
  localparam int BURST_BIT  = 4;
  localparam int BLEN_LSB   = 5;
  localparam int BLEN_W     = 4;
  localparam int ID_W       = 5;
  localparam int ID_LSB     = 63;
  localparam int SRAM_AW    = 22;
  localparam int OCC_BIT    = 0;

  // ---------------------------------------------------------------------------
  // Encodings.
  // ---------------------------------------------------------------------------
  localparam logic [CMD_W-1:0] CMD_READ   = 2'h0;
  localparam logic [CMD_W-1:0] CMD_WRITE  = 2'h1;
  localparam logic [CMD_W-1:0] CMD_SEARCH = 2'h2;
  localparam logic [CMD_W-1:0] CMD_LEARN  = 2'h3;
  localparam logic [TGT_W-1:0] TGT_DATA   = 2'h0;
  localparam logic [TGT_W-1:0] TGT_MASK   = 2'h1;
  localparam logic [TGT_W-1:0] TGT_SRAM   = 2'h2;
  localparam logic [ID_W-1:0]  BCAST_ID   = 5'h1F;

  // ---------------------------------------------------------------------------
  // Defaults and counts.
  // ---------------------------------------------------------------------------
  localparam int DEPTH_DEF      = 64;
  localparam int SEARCH_LAT_DEF = 4;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WRITE,
    ST_READ,
    ST_SRAM_RD
  } tse_state_t;

endpackage

// file: tse_prio_enc.sv
// Lowest-index priority encoder used for search hits and free-entry lookup.
module tse_prio_enc #(
  parameter int N = 64
) (
  // Requests.
  input  wire logic [N-1:0]         req_i,
  // Result.
  output logic                      any_o,
  output logic [$clog2(N)-1:0]      idx_o
);

  localparam int AW = $clog2(N);

  if (N < 2) begin : g_chk
    $error("tse_prio_enc needs N of at least 2");
  end

  // ---------------------------------------------------------------------------
  // Scan from the top so the lowest set request is left standing.
  // ---------------------------------------------------------------------------
  always_comb begin
    any_o = |req_i;
    idx_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        idx_o = AW'(i);
      end
    end
  end

endmodule

// file: tse_front.sv
// Command decode, ternary search, learn, cascade arbitration and SRAM drive.
module tse_front #(
  parameter int DEPTH      = tse_pkg::DEPTH_DEF,
  parameter int SEARCH_LAT = tse_pkg::SEARCH_LAT_DEF
) (
  // Clock, phase and reset.
  input  wire logic                        sys_clk_i,
  input  wire logic                        sys_rst_i,
  input  wire logic                        phase_select_n_i,
  // Command and shared bus.
  input  wire logic [tse_pkg::OP_W-1:0]    op_i,
  input  wire logic                        op_valid_i,
  input  wire logic [tse_pkg::DQ_W-1:0]    dq_i,
  output logic      [tse_pkg::DQ_W-1:0]    dq_o,
  output logic                             dq_oe_o,
  // Cascade configuration.
  input  wire logic [tse_pkg::ID_W-1:0]    device_id_i,
  input  wire logic                        last_in_chain_bit_i,
  input  wire logic                        broadcast_responder_bit_i,
  // Cascade hit and full chain.
  input  wire logic                        hit_in_i,
  output logic                             hit_out_o,
  input  wire logic                        full_in_i,
  output logic                             full_out_o,
  output logic                             table_full_o,
  // Three-state status strobes.
  output logic                             read_valid_o,
  output logic                             read_valid_oe_o,
  output logic                             burst_end_o,
  output logic                             burst_end_oe_o,
  output logic                             search_win_flag_o,
  output logic                             search_win_valid_o,
  output logic                             search_win_oe_o,
  // SRAM interface.
  output logic      [tse_pkg::SRAM_AW-1:0] sram_index_out_o,
  output logic                             sram_index_oe_o,
  output logic                             sram_cs_n_o,
  output logic                             sram_ale_n_o,
  output logic                             sram_we_n_o,
  output logic                             sram_ctl_oe_o,
  output logic                             sram_read_en_n_o,
  output logic                             sram_read_en_oe_o
);

  localparam int AW = $clog2(DEPTH);
  localparam int L  = SEARCH_LAT;

  if (DEPTH < 2 || (1 << AW) != DEPTH || AW + tse_pkg::ID_W > tse_pkg::SRAM_AW) begin : g_chk_d
    $error("tse_front DEPTH must be a power of two that fits the SRAM index");
  end
  if (L < 2) begin : g_chk_l
    $error("tse_front SEARCH_LAT must be at least 2");
  end

  // ---------------------------------------------------------------------------
  // Input sampling on every master clock edge.
  // ---------------------------------------------------------------------------
  logic [tse_pkg::OP_W-1:0] in_op_r;
  logic                     in_vld_r;
  logic [tse_pkg::DQ_W-1:0] in_dq_r;
  logic                     in_hit_r;
  logic                     in_full_r;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      in_op_r   <= '0;
      in_vld_r  <= 1'b0;
      in_dq_r   <= '0;
      in_hit_r  <= 1'b0;
      in_full_r <= 1'b0;
    end else begin
      in_op_r   <= op_i;
      in_vld_r  <= op_valid_i;
      in_dq_r   <= dq_i;
      in_hit_r  <= hit_in_i;
      in_full_r <= full_in_i;
    end
  end

  // ---------------------------------------------------------------------------
  // Internal clock tick and command decode.
  // ---------------------------------------------------------------------------
  logic                          tick;
  logic                          cmd_go;
  logic [tse_pkg::CMD_W-1:0]     cmd;
  logic [tse_pkg::TGT_W-1:0]     tgt;
  logic [tse_pkg::ID_W-1:0]      adr_id;
  logic                          is_bcast;
  logic                          wr_sel;
  logic                          rd_sel;
  logic [AW-1:0]                 adr_idx;

  assign tick     = ~phase_select_n_i;
  assign cmd_go   = tick & in_vld_r;
  assign cmd      = in_op_r[tse_pkg::CMD_LSB +: tse_pkg::CMD_W];
  assign tgt      = in_op_r[tse_pkg::TGT_LSB +: tse_pkg::TGT_W];
  assign adr_id   = in_dq_r[tse_pkg::ID_LSB +: tse_pkg::ID_W];
  assign is_bcast = adr_id == tse_pkg::BCAST_ID;
  assign wr_sel   = is_bcast | (adr_id == device_id_i);
  assign rd_sel   = (is_bcast & broadcast_responder_bit_i) | (adr_id == device_id_i);
  assign adr_idx  = in_dq_r[AW-1:0];

  // ---------------------------------------------------------------------------
  // Entry storage and ternary compare.
  // ---------------------------------------------------------------------------
  logic [tse_pkg::DQ_W-1:0] data_mem [DEPTH];
  logic [tse_pkg::DQ_W-1:0] mask_mem [DEPTH];
  logic [DEPTH-1:0]         match_vec;
  logic [DEPTH-1:0]         free_vec;

  for (genvar g = 0; g < DEPTH; g++) begin : g_cmp
    assign match_vec[g] = &((data_mem[g] ~^ in_dq_r) | mask_mem[g]);
    assign free_vec[g]  = ~data_mem[g][tse_pkg::OCC_BIT];
  end

  logic          loc_hit;
  logic [AW-1:0] loc_idx;
  logic          free_any;
  logic [AW-1:0] free_idx;

  tse_prio_enc #(
    .N     (DEPTH)
  ) u_hit_enc (
    .req_i (match_vec),
    .any_o (loc_hit),
    .idx_o (loc_idx)
  );

  tse_prio_enc #(
    .N     (DEPTH)
  ) u_free_enc (
    .req_i (free_vec),
    .any_o (free_any),
    .idx_o (free_idx)
  );

  // ---------------------------------------------------------------------------
  // Programmed access sequencer.
  // ---------------------------------------------------------------------------
  tse_pkg::tse_state_t          state_r;
  logic [AW-1:0]                ptr_r;
  logic [tse_pkg::BLEN_W-1:0]   cnt_r;
  logic                         burst_r;
  logic                         tgt_mask_r;
  logic                         do_learn;
  logic                         last_word;

  assign do_learn  = cmd_go & (cmd == tse_pkg::CMD_LEARN) & free_any & in_full_r;
  assign last_word = cnt_r == '0;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_r    <= tse_pkg::ST_IDLE;
      ptr_r      <= '0;
      cnt_r      <= '0;
      burst_r    <= 1'b0;
      tgt_mask_r <= 1'b0;
    end else if (tick) begin
      unique case (state_r)
        tse_pkg::ST_IDLE: begin
          if (cmd_go) begin
            ptr_r      <= adr_idx;
            tgt_mask_r <= tgt == tse_pkg::TGT_MASK;
            burst_r    <= in_op_r[tse_pkg::BURST_BIT];
            cnt_r      <= in_op_r[tse_pkg::BURST_BIT] ?
                          in_op_r[tse_pkg::BLEN_LSB +: tse_pkg::BLEN_W] : '0;
            if (cmd == tse_pkg::CMD_READ && rd_sel) begin
              if (tgt == tse_pkg::TGT_SRAM) begin
                state_r <= tse_pkg::ST_SRAM_RD;
              end else if (tgt != 2'h3) begin
                state_r <= tse_pkg::ST_READ;
              end
            end else if (cmd == tse_pkg::CMD_WRITE && wr_sel &&
                         (tgt == tse_pkg::TGT_DATA || tgt == tse_pkg::TGT_MASK)) begin
              state_r <= tse_pkg::ST_WRITE;
            end
          end
        end
        tse_pkg::ST_WRITE, tse_pkg::ST_READ: begin
          ptr_r <= ptr_r + AW'(1);
          cnt_r <= cnt_r - 4'h1;
          if (last_word) begin
            state_r <= tse_pkg::ST_IDLE;
          end
        end
        tse_pkg::ST_SRAM_RD: begin
          state_r <= tse_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Array writes, learn and reset clearing.
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        data_mem[i] <= '0;
        mask_mem[i] <= '0;
      end
    end else if (tick) begin
      if (state_r == tse_pkg::ST_WRITE) begin
        if (tgt_mask_r) begin
          mask_mem[ptr_r] <= in_dq_r;
        end else begin
          data_mem[ptr_r] <= in_dq_r;
        end
      end else if (do_learn) begin
        data_mem[free_idx] <= {in_dq_r[tse_pkg::DQ_W-1:1], 1'b1};
        mask_mem[free_idx] <= '0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Shared bus read drive, read valid strobe and read/write burst end strobe.
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      dq_o            <= '0;
      dq_oe_o         <= 1'b0;
      read_valid_o    <= 1'b0;
      read_valid_oe_o <= 1'b0;
      burst_end_o     <= 1'b0;
      burst_end_oe_o  <= 1'b0;
    end else if (tick) begin
      dq_oe_o         <= state_r == tse_pkg::ST_READ;
      dq_o            <= tgt_mask_r ? mask_mem[ptr_r] : data_mem[ptr_r];
      read_valid_o    <= state_r == tse_pkg::ST_READ || state_r == tse_pkg::ST_SRAM_RD;
      read_valid_oe_o <= state_r == tse_pkg::ST_READ || state_r == tse_pkg::ST_SRAM_RD;
      burst_end_o     <= burst_r && last_word &&
                         (state_r == tse_pkg::ST_READ || state_r == tse_pkg::ST_WRITE);
      burst_end_oe_o  <= burst_r &&
                         (state_r == tse_pkg::ST_READ || state_r == tse_pkg::ST_WRITE);
    end
  end

  // ---------------------------------------------------------------------------
  // Search pipeline with cascade arbitration.
  // ---------------------------------------------------------------------------
  logic [L-1:0]  sp_vld_r;
  logic [L-1:0]  sp_win_r;
  logic [L-1:0]  sp_any_r;
  logic [AW-1:0] sp_idx_r [L];

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sp_vld_r <= '0;
      sp_win_r <= '0;
      sp_any_r <= '0;
      for (int k = 0; k < L; k++) begin
        sp_idx_r[k] <= '0;
      end
    end else if (tick) begin
      sp_vld_r[0] <= cmd_go & (cmd == tse_pkg::CMD_SEARCH);
      sp_win_r[0] <= cmd_go & (cmd == tse_pkg::CMD_SEARCH) & loc_hit;
      sp_any_r[0] <= 1'b0;
      sp_idx_r[0] <= loc_idx;
      sp_vld_r[1] <= sp_vld_r[0];
      sp_win_r[1] <= sp_win_r[0] & ~in_hit_r;
      sp_any_r[1] <= sp_win_r[0] | (sp_vld_r[0] & in_hit_r);
      sp_idx_r[1] <= sp_idx_r[0];
      for (int k = 2; k < L; k++) begin
        sp_vld_r[k] <= sp_vld_r[k-1];
        sp_win_r[k] <= sp_win_r[k-1];
        sp_any_r[k] <= sp_any_r[k-1];
        sp_idx_r[k] <= sp_idx_r[k-1];
      end
    end
  end

  assign hit_out_o = sp_win_r[0];

  // ---------------------------------------------------------------------------
  // Win flags, qualifier and SRAM pins.
  // ---------------------------------------------------------------------------
  logic s_win;
  logic s_miss_all;
  logic s_any;
  logic pio_sram;

  assign s_win      = sp_vld_r[L-1] & sp_win_r[L-1];
  assign s_any      = sp_vld_r[L-1] & sp_any_r[L-1];
  assign s_miss_all = sp_vld_r[L-1] & ~sp_any_r[L-1] & last_in_chain_bit_i;
  assign pio_sram   = cmd_go & (tgt == tse_pkg::TGT_SRAM) &
                      ((cmd == tse_pkg::CMD_READ && rd_sel) ||
                       (cmd == tse_pkg::CMD_WRITE && rd_sel)) &&
                      state_r == tse_pkg::ST_IDLE;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      search_win_flag_o  <= 1'b0;
      search_win_valid_o <= 1'b0;
      search_win_oe_o    <= 1'b0;
    end else if (tick) begin
      search_win_flag_o  <= s_win;
      search_win_valid_o <= s_win | s_miss_all;
      search_win_oe_o    <= s_win | s_miss_all;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sram_index_out_o  <= '0;
      sram_index_oe_o   <= 1'b0;
      sram_cs_n_o       <= 1'b1;
      sram_ale_n_o      <= 1'b1;
      sram_we_n_o       <= 1'b1;
      sram_ctl_oe_o     <= 1'b0;
      sram_read_en_n_o  <= 1'b1;
      sram_read_en_oe_o <= 1'b0;
    end else if (tick) begin
      sram_index_oe_o   <= s_win | pio_sram;
      sram_ctl_oe_o     <= s_win | pio_sram;
      sram_cs_n_o       <= ~(s_win | pio_sram);
      sram_ale_n_o      <= ~(s_win | pio_sram);
      sram_we_n_o       <= ~(pio_sram & ~s_win & (cmd == tse_pkg::CMD_WRITE));
      sram_read_en_oe_o <= last_in_chain_bit_i;
      sram_read_en_n_o  <= ~(last_in_chain_bit_i &
                            (s_any | (pio_sram & (cmd == tse_pkg::CMD_READ))));
      if (s_win) begin
        sram_index_out_o <= tse_pkg::SRAM_AW'({device_id_i, sp_idx_r[L-1]});
      end else if (pio_sram) begin
        sram_index_out_o <= in_dq_r[tse_pkg::SRAM_AW-1:0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Full chain.
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      full_out_o   <= 1'b0;
      table_full_o <= 1'b0;
    end else if (tick) begin
      full_out_o   <= ~|free_vec;
      table_full_o <= ~|free_vec & in_full_r;
    end
  end

endmodule

// file: tse_front_sva.sv
// Port checker for the search engine front end.
module tse_front_sva #(
  parameter int DEPTH      = 64,
  parameter int SEARCH_LAT = 4
) (
  // Clock, phase and reset.
  input wire logic                        sys_clk_i,
  input wire logic                        sys_rst_i,
  input wire logic                        phase_select_n_i,
  // Command and cascade inputs.
  input wire logic [tse_pkg::OP_W-1:0]    op_i,
  input wire logic                        op_valid_i,
  input wire logic                        hit_in_i,
  input wire logic                        full_in_i,
  input wire logic                        last_in_chain_bit_i,
  // Outputs watched.
  input wire logic [tse_pkg::DQ_W-1:0]    dq_o,
  input wire logic                        dq_oe_o,
  input wire logic                        table_full_o,
  input wire logic                        read_valid_o,
  input wire logic                        read_valid_oe_o,
  input wire logic                        burst_end_o,
  input wire logic                        burst_end_oe_o,
  input wire logic                        search_win_flag_o,
  input wire logic                        search_win_valid_o,
  input wire logic                        search_win_oe_o,
  input wire logic [tse_pkg::SRAM_AW-1:0] sram_index_out_o,
  input wire logic                        sram_index_oe_o,
  input wire logic                        sram_cs_n_o,
  input wire logic                        sram_ale_n_o,
  input wire logic                        sram_ctl_oe_o,
  input wire logic                        sram_read_en_oe_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  // ---------------------------------------------------------------------------
  // Sequences and properties.
  // ---------------------------------------------------------------------------
  sequence s_srch;
    op_valid_i && phase_select_n_i && op_i[1:0] == tse_pkg::CMD_SEARCH
      && last_in_chain_bit_i && !hit_in_i;
  endsequence
  sequence s_win;
    search_win_flag_o && search_win_oe_o;
  endsequence
  property p_reset;
    disable iff (1'b0) sys_rst_i |=> !dq_oe_o && !read_valid_oe_o && !search_win_oe_o
      && sram_cs_n_o && !table_full_o;
  endproperty

  // ---------------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------------
  chk_tick_only: assert property (phase_select_n_i |=> $stable({dq_o, dq_oe_o,
    read_valid_o, burst_end_o, search_win_flag_o, search_win_valid_o, sram_index_out_o,
    sram_cs_n_o, table_full_o}))
    else $error("output moved on a phase-high edge");
  chk_srch_lat: assert property (s_srch |-> ##[2:12] search_win_valid_o)
    else $error("search gave no qualified result in time");
  chk_win_qual: assert property (search_win_flag_o |-> search_win_valid_o
    && search_win_oe_o)
    else $error("win flag without its qualifier");
  chk_win_sram: assert property (s_win |-> sram_index_oe_o && !sram_cs_n_o
    && !sram_ale_n_o && sram_ctl_oe_o)
    else $error("winner did not drive the sram cycle");
  chk_up_hit: assert property (hit_in_i && phase_select_n_i |-> ##[8:9] !search_win_flag_o)
    else $error("win flag despite upstream hit");
  chk_full_in: assert property (!full_in_i [*4] |-> !table_full_o)
    else $error("table full while upstream not full");
  chk_rden_last: assert property (!last_in_chain_bit_i [*3] |-> !sram_read_en_oe_o)
    else $error("sram read enable driven by non-last device");
  chk_rv_drive: assert property (read_valid_o |-> read_valid_oe_o)
    else $error("read strobe high while released");
  chk_burst_drive: assert property (burst_end_o |-> burst_end_oe_o)
    else $error("burst end high while released");
  chk_reset_idle: assert property (p_reset)
    else $error("outputs not idle after reset");
endmodule

bind tse_front tse_front_sva #(.DEPTH(DEPTH), .SEARCH_LAT(SEARCH_LAT)) i_sva (
  .sys_clk_i, .sys_rst_i, .phase_select_n_i, .op_i, .op_valid_i, .hit_in_i, .full_in_i,
  .last_in_chain_bit_i, .dq_o, .dq_oe_o, .table_full_o, .read_valid_o, .read_valid_oe_o,
  .burst_end_o, .burst_end_oe_o, .search_win_flag_o, .search_win_valid_o, .search_win_oe_o,
  .sram_index_out_o, .sram_index_oe_o, .sram_cs_n_o, .sram_ale_n_o, .sram_ctl_oe_o,
  .sram_read_en_oe_o);

// file: tse_peer.sv
// Host-side peer: phase source and upstream cascade device.
module tse_peer (
  // Clock.
  input  wire logic clk_i,
  // Upstream state set by the bench.
  input  wire logic up_hit_i,
  input  wire logic up_full_i,
  // Towards the device.
  output logic      phase_n_o,
  output logic      hit_o,
  output logic      full_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial phase_n_o = 1'b0;
  always @(posedge clk_i) phase_n_o <= ~phase_n_o;
  assign hit_o  = up_hit_i;
  assign full_o = up_full_i;
endmodule

// file: tb.sv
// Self-checking bench for the search engine front end.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         D   = 8;
  localparam logic [4:0] DEV = 5'h06;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        up_hit = 1'b0;
  logic        up_full = 1'b1;
  logic [8:0]  op = 9'h000;
  logic        ov = 1'b0;
  logic [67:0] dq = 68'h0;
  logic        last = 1'b1;
  logic        resp = 1'b0;
  logic        ph, hit_in, full_in, dq_oe, rv, be, wf, wv, tf, cs_n, lho, fo, we_n, re_n;
  logic [24:0] snap;
  logic [67:0] dq_o;
  logic [21:0] sx;
  logic [67:0] md [D];
  logic [67:0] mm [D];
  int          mismatches = 0;
  int          n_compared = 0;
  int          seed = 35;
  int          nh = 0;

  always #5 clk = ~clk;
  always @(posedge clk) if (lho !== 1'b0) nh++;
  tse_peer i_peer (.clk_i(clk), .up_hit_i(up_hit), .up_full_i(up_full), .phase_n_o(ph),
    .hit_o(hit_in), .full_o(full_in));
  tse_front #(.DEPTH(D), .SEARCH_LAT(4)) i_dut (.sys_clk_i(clk), .sys_rst_i(rst),
    .phase_select_n_i(ph), .op_i(op), .op_valid_i(ov), .dq_i(dq), .dq_o(dq_o),
    .dq_oe_o(dq_oe), .device_id_i(DEV), .last_in_chain_bit_i(last),
    .broadcast_responder_bit_i(resp), .hit_in_i(hit_in), .hit_out_o(lho), .full_in_i(full_in),
    .full_out_o(fo), .table_full_o(tf), .read_valid_o(rv), .read_valid_oe_o(),
    .burst_end_o(be), .burst_end_oe_o(), .search_win_flag_o(wf), .search_win_valid_o(wv),
    .search_win_oe_o(), .sram_index_out_o(sx), .sram_index_oe_o(), .sram_cs_n_o(cs_n),
    .sram_ale_n_o(), .sram_we_n_o(we_n), .sram_ctl_oe_o(), .sram_read_en_n_o(re_n),
    .sram_read_en_oe_o());

  // ---------------------------------------------------------------------------
  // Helpers.
  // ---------------------------------------------------------------------------
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [67:0] e, input logic [67:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [67:0] rnd();
    return 68'({$random(seed), $random(seed), $random(seed)});
  endfunction
  function automatic int low(input logic [67:0] k);
    for (int i = 0; i < D; i++) if (((md[i] ^ k) & ~mm[i]) === 68'h0) return i;
    return -1;
  endfunction
  function automatic logic [67:0] aw(input logic [4:0] dv, input int i);
    return {dv, 60'h0, 3'(i)};
  endfunction
  task automatic tk;
    @(posedge clk);
    while (ph !== 1'b0) @(posedge clk);
  endtask
  task automatic cmd(input logic [8:0] o, input logic v, input logic [67:0] a,
                     input logic [67:0] b);
    tk;
    op <= o;
    ov <= v;
    dq <= a;
    tk;
    ov <= 1'b0;
    dq <= b;
    #1;
    snap = {cs_n, we_n, re_n, sx};
    tk;
    dq <= ~b;
  endtask
  task automatic wr(input logic [4:0] dv, input logic [1:0] t, input int i,
                    input logic [67:0] d);
    cmd({5'h00, t, 2'h1}, 1'b1, aw(dv, i), d);
    if (t == 2'h0) md[i] = d;
    else mm[i] = d;
  endtask
  task automatic rd(input logic [4:0] dv, input logic [1:0] t, input int i, input int n,
                    input logic ok);
    logic [67:0] e;
    cmd({4'(n - 1), 1'(n > 1), t, 2'h0}, 1'b1, aw(dv, i), ~aw(dv, i));
    for (int w = 0; w < n; w++) begin
      #1;
      e = (t == 2'h0) ? md[(i + w) % D] : mm[(i + w) % D];
      chk("read_valid", ok, rv);
      if (ok) chk("read_data", e, dq_o);
      if (n > 1) chk("burst_end", 1'(w == n - 1), be);
      tk;
    end
  endtask
  task automatic srch(input logic [67:0] k, input logic v);
    int          e;
    int          n0;
    logic        sv;
    logic        sf;
    logic [21:0] si;
    e = low(k);
    sv = 1'b0;
    sf = 1'b0;
    si = '0;
    n0 = nh;
    cmd({7'h00, 2'h2}, v, k, ~k);
    repeat (10) begin
      tk;
      #1;
      if (wv === 1'b1 && !sv) begin
        sv = 1'b1;
        sf = wf;
        si = sx;
      end
    end
    if (!up_hit) chk("win_valid", v, sv);
    chk("hit_out", 68'(2 * (v && e >= 0)), 68'(nh - n0));
    chk("win_flag", v && !up_hit && e >= 0, sf);
    if (sf === 1'b1) chk("sram_index", {14'h0, DEV, 3'(e)}, si);
  endtask
  task automatic lrn(input logic [67:0] k);
    int f;
    f = -1;
    for (int i = D - 1; i >= 0; i--) if (md[i][0] === 1'b0) f = i;
    cmd({7'h00, 2'h3}, 1'b1, k, ~k);
    if (f >= 0 && up_full) begin
      md[f] = k | 68'h1;
      mm[f] = '0;
    end
  endtask
  task automatic sr(input logic [1:0] c, input logic [21:0] a);
    cmd({5'h00, 2'h2, c}, 1'b1, {DEV, 41'h0, a}, 68'h0);
    #1;
    chk("sram_pins", {1'b0, c != 2'h1, c != 2'h0, a}, snap);
    chk("read_valid", c == 2'h0, rv);
  endtask
  task automatic full_chk;
    logic e;
    logic eo;
    #1;
    eo = 1'b1;
    for (int i = 0; i < D; i++) eo &= md[i][0];
    e = up_full & eo;
    repeat (8) begin
      tk;
      #1;
      if (tf === e && fo === eo) break;
    end
    chk("table_full", e, tf);
    chk("full_out", eo, fo);
  endtask

  // ---------------------------------------------------------------------------
  // Tests.
  // ---------------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done;
  end
  initial begin
    for (int i = 0; i < D; i++) begin
      md[i] = '0;
      mm[i] = '0;
    end
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    tk;
    #1;
    chk("reset_dq_oe", 1'b0, dq_oe);
    chk("reset_cs_n", 1'b1, cs_n);
    chk("reset_full", 1'b0, tf);
    $display("test reset done");
    for (int i = 1; i < 6; i++) wr(DEV, 2'h0, i, rnd() | 68'h1);
    wr(DEV, 2'h0, 4, md[2]);
    wr(DEV, 2'h1, 3, rnd());
    wr(5'h1F, 2'h0, 6, rnd() | 68'h1);
    for (int j = 0; j < 12; j++) srch(md[1 + j % 6] ^ (mm[1 + j % 6] & rnd()), 1'b1);
    srch(rnd() & ~68'h1, 1'b1);
    srch(md[5], 1'b0);
    @(posedge clk) up_hit <= 1'b1;
    srch(md[1], 1'b1);
    @(posedge clk) up_hit <= 1'b0;
    $display("test search done");
    @(posedge clk) last <= 1'b0;
    rd(DEV, 2'h0, 1, 1, 1'b1);
    rd(DEV, 2'h1, 3, 1, 1'b1);
    rd(DEV, 2'h0, 2, 3, 1'b1);
    rd(5'h1F, 2'h0, 5, 1, 1'b0);
    resp <= 1'b1;
    rd(5'h1F, 2'h0, 5, 1, 1'b1);
    rd(5'h03, 2'h0, 5, 1, 1'b0);
    last <= 1'b1;
    sr(2'h1, 22'($random(seed)));
    sr(2'h0, 22'($random(seed)));
    $display("test read done");
    full_chk;
    for (int i = 0; i < 3; i++) lrn(rnd());
    full_chk;
    srch(md[7], 1'b1);
    @(posedge clk) up_full <= 1'b0;
    full_chk;
    $display("test learn done");
    test_done;
  end
endmodule
